// ### design/port5_link_and_storm_regs.svh
// register offsets, field positions, reset values and timing for the port-5 link block
`ifndef PORT5_LINK_AND_STORM_REGS_SVH
`define PORT5_LINK_AND_STORM_REGS_SVH

// -----------------------------------------------------------------
// offsets
// -----------------------------------------------------------------
`define OFS_PORT5_LINK_AND_STORM_HIGH 8'h06
`define OFS_STORM_RATE_LOW_BYTE       8'h07
`define OFS_FACTORY_TEST_A            8'h08
`define OFS_FACTORY_TEST_B            8'h09
`define OFS_FACTORY_TEST_C            8'h0a
`define OFS_GLOBAL_CONTROL_NINE       8'h0b

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define BIT_HALF_DUPLEX     6
`define BIT_PAUSE_EN        5
`define BIT_SPEED_10        4
`define BIT_NULL_VID_REPL   3
`define BIT_CTL9_EDGE_SEL   6
`define BIT_CTL9_POWER_SAVE 3

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define RST_STORM_RATE    11'h04a
`define RST_FACTORY_TEST_A 8'h00
`define RST_FACTORY_TEST_B 8'h4c
`define RST_FACTORY_TEST_C 8'h00

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define MCLK_KHZ          100000
`define STORM_PERIOD_100_MS 50
`define STORM_PERIOD_10_MS  500
`define STORM_PERIOD_RATIO  (`STORM_PERIOD_10_MS / `STORM_PERIOD_100_MS)

`endif

// ### design/port5_link_and_storm_pkg.sv
// types shared by the port-5 link and storm control block
package port5_link_and_storm_pkg;
  typedef logic [7:0]  reg_byte_t;
  typedef logic [10:0] storm_rate_t;
  typedef logic [11:0] block_count_t;
endpackage : port5_link_and_storm_pkg

// ### design/port5_link_and_storm_control_regs.sv
// port-5 link settings, null-vid replacement, storm control and factory-test registers
// What this block does
// - duplex bit 6: one selects half duplex, zero full duplex
// - duplex bit loads from duplex strap at reset, pull-down means full duplex
// - pause bit 5 enables full-duplex pause flow control on port-5 interface
// - pause bit loads from pause strap at reset, default disabled
// - speed bit 4: one selects 10 Mbps, zero selects 100 Mbps
// - speed bit loads from speed strap at reset, default 100 Mbps
// - bit 3 set replaces null vlan identifier with port default identifier
// - storm threshold is 11 bits, [10:8] then [7:0], 64-byte blocks per period
// - storm period is 50 ms at 100 Mbps and 500 ms at 10 Mbps
// - storm threshold resets to 0x4a, upper bits zero
`timescale 1ns/10ps
`default_nettype none
`include "port5_link_and_storm_regs.svh"

module port5_link_and_storm_control_regs #(
  parameter int unsigned NUM_PORTS = 5,
  parameter int unsigned P100_CYC  = `STORM_PERIOD_100_MS * `MCLK_KHZ
) (
  // clock and reset
  input  wire logic                   i_mclk,
  input  wire logic                   i_sys_rst,
  // register access port
  input  wire logic                   i_reg_wr,
  input  wire logic                   i_reg_rd,
  input  wire logic [7:0]             i_reg_addr,
  input  wire logic [7:0]             i_reg_wdata,
  output logic      [7:0]             o_reg_rdata,
  // strap pins
  input  wire logic                   i_duplex_strap_input,
  input  wire logic                   i_pause_strap_input,
  input  wire logic                   i_speed_strap_input,
  // port-5 switch-side interface settings
  output logic                        o_half_duplex,
  output logic                        o_pause_en,
  output logic                        o_speed_10,
  output logic                        o_null_vid_replace,
  output logic      [10:0]            o_storm_rate,
  // broadcast storm per input port
  input  wire logic [NUM_PORTS-1:0]   i_port_speed_10,
  input  wire logic [NUM_PORTS-1:0]   i_bcast_block,
  output logic      [NUM_PORTS-1:0]   o_bcast_drop
);

  // -----------------------------------------------------------------
  // strap synchronisers
  // -----------------------------------------------------------------
  logic [2:0] strap_s1_r, strap_s2_r, strap_s3_r;
  logic [2:0] strap_ok;

  always_ff @(posedge i_mclk) begin
    strap_s1_r <= {i_duplex_strap_input, i_pause_strap_input, i_speed_strap_input};
    strap_s2_r <= strap_s1_r;
    strap_s3_r <= strap_s2_r;
  end
  assign strap_ok = ~(strap_s2_r ^ strap_s3_r);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // -----------------------------------------------------------------
  // control registers
  // -----------------------------------------------------------------
  logic                              half_duplex_r, half_duplex_nxt;
  logic                              pause_en_r, pause_en_nxt;
  logic                              speed_10_r, speed_10_nxt;
  logic                              null_vid_r, null_vid_nxt;
  port5_link_and_storm_pkg::storm_rate_t rate_r, rate_nxt;
  logic [1:0]                        ctl9_r, ctl9_nxt;
  logic                              wr_high, wr_low, wr_nine;

  assign wr_high = i_reg_wr & hit(i_reg_addr, `OFS_PORT5_LINK_AND_STORM_HIGH);
  assign wr_low  = i_reg_wr & hit(i_reg_addr, `OFS_STORM_RATE_LOW_BYTE);
  assign wr_nine = i_reg_wr & hit(i_reg_addr, `OFS_GLOBAL_CONTROL_NINE);

  always_comb begin
    half_duplex_nxt = half_duplex_r;
    pause_en_nxt    = pause_en_r;
    speed_10_nxt    = speed_10_r;
    null_vid_nxt    = null_vid_r;
    rate_nxt        = rate_r;
    ctl9_nxt        = ctl9_r;
    if (i_sys_rst) begin
      if (strap_ok[2]) half_duplex_nxt = strap_s3_r[2];
      if (strap_ok[1]) pause_en_nxt = strap_s3_r[1];
      if (strap_ok[0]) speed_10_nxt = strap_s3_r[0];
      null_vid_nxt = 1'b0;
      rate_nxt     = `RST_STORM_RATE;
      ctl9_nxt     = 2'h0;
    end else begin
      if (wr_high) begin
        half_duplex_nxt = i_reg_wdata[`BIT_HALF_DUPLEX];
        pause_en_nxt    = i_reg_wdata[`BIT_PAUSE_EN];
        speed_10_nxt    = i_reg_wdata[`BIT_SPEED_10];
        null_vid_nxt    = i_reg_wdata[`BIT_NULL_VID_REPL];
        rate_nxt[10:8]  = i_reg_wdata[2:0];
      end
      if (wr_low) rate_nxt[7:0] = i_reg_wdata;
      if (wr_nine) ctl9_nxt = {i_reg_wdata[`BIT_CTL9_EDGE_SEL], i_reg_wdata[`BIT_CTL9_POWER_SAVE]};
    end
  end

  always_ff @(posedge i_mclk) begin
    half_duplex_r <= half_duplex_nxt;
    pause_en_r    <= pause_en_nxt;
    speed_10_r    <= speed_10_nxt;
    null_vid_r    <= null_vid_nxt;
    rate_r        <= rate_nxt;
    ctl9_r        <= ctl9_nxt;
  end

  assign o_half_duplex      = half_duplex_r;
  assign o_pause_en         = pause_en_r;
  assign o_speed_10         = speed_10_r;
  assign o_null_vid_replace = null_vid_r;
  assign o_storm_rate       = rate_r;

  // -----------------------------------------------------------------
  // read data
  // -----------------------------------------------------------------
  port5_link_and_storm_pkg::reg_byte_t rdata_r, rdata_nxt;

  always_comb begin
    rdata_nxt = rdata_r;
    if (i_sys_rst) begin
      rdata_nxt = 8'h00;
    end else if (i_reg_rd) begin
      rdata_nxt = 8'h00;
      if (hit(i_reg_addr, `OFS_PORT5_LINK_AND_STORM_HIGH))
        rdata_nxt = {1'b0, half_duplex_r, pause_en_r, speed_10_r, null_vid_r, rate_r[10:8]};
      if (hit(i_reg_addr, `OFS_STORM_RATE_LOW_BYTE)) rdata_nxt = rate_r[7:0];
      if (hit(i_reg_addr, `OFS_FACTORY_TEST_A)) rdata_nxt = `RST_FACTORY_TEST_A;
      if (hit(i_reg_addr, `OFS_FACTORY_TEST_B)) rdata_nxt = `RST_FACTORY_TEST_B;
      if (hit(i_reg_addr, `OFS_FACTORY_TEST_C)) rdata_nxt = `RST_FACTORY_TEST_C;
      if (hit(i_reg_addr, `OFS_GLOBAL_CONTROL_NINE))
        rdata_nxt = {1'b0, ctl9_r[1], 2'h0, ctl9_r[0], 3'h0};
    end
  end

  always_ff @(posedge i_mclk) begin
    rdata_r <= rdata_nxt;
  end
  assign o_reg_rdata = rdata_r;

  // -----------------------------------------------------------------
  // storm period timer
  // -----------------------------------------------------------------
  logic [31:0] tmr_r, tmr_nxt;
  logic [3:0]  sub_r, sub_nxt;
  logic        tick_100, tick_10;

  assign tick_100 = (tmr_r == P100_CYC - 1);
  assign tick_10  = tick_100 && (sub_r == 4'(`STORM_PERIOD_RATIO - 1));

  always_comb begin
    tmr_nxt = tmr_r + 32'h1;
    sub_nxt = sub_r;
    if (i_sys_rst) begin
      tmr_nxt = 32'h0;
      sub_nxt = 4'h0;
    end else if (tick_100) begin
      tmr_nxt = 32'h0;
      sub_nxt = tick_10 ? 4'h0 : sub_r + 4'h1;
    end
  end

  always_ff @(posedge i_mclk) begin
    tmr_r <= tmr_nxt;
    sub_r <= sub_nxt;
  end

  // -----------------------------------------------------------------
  // per-port block counters and drop flags
  // -----------------------------------------------------------------
  port5_link_and_storm_pkg::block_count_t cnt_r [NUM_PORTS];
  port5_link_and_storm_pkg::block_count_t cnt_nxt [NUM_PORTS];
  logic [NUM_PORTS-1:0] drop_r, drop_nxt;

  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      cnt_nxt[p]  = cnt_r[p];
      drop_nxt[p] = drop_r[p];
      if (i_sys_rst) begin
        cnt_nxt[p]  = 12'h000;
        drop_nxt[p] = 1'b0;
      end else if (i_port_speed_10[p] ? tick_10 : tick_100) begin
        cnt_nxt[p]  = 12'h000;
        drop_nxt[p] = 1'b0;
      end else begin
        if (i_bcast_block[p] && cnt_r[p] != 12'hfff) cnt_nxt[p] = cnt_r[p] + 12'h001;
        drop_nxt[p] = (cnt_nxt[p] > {1'b0, rate_r});
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    cnt_r  <= cnt_nxt;
    drop_r <= drop_nxt;
  end
  assign o_bcast_drop = drop_r;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  chk_duplex_write: assert property (wr_high |=> o_half_duplex == $past(i_reg_wdata[6]))
    else $error("duplex bit not written");
  chk_duplex_strap: assert property (disable iff (1'b0)
    i_sys_rst && strap_ok[2] |=> o_half_duplex == $past(strap_s3_r[2]))
    else $error("duplex strap not loaded");
  chk_pause_write: assert property (wr_high |=> o_pause_en == $past(i_reg_wdata[5]))
    else $error("pause bit not written");
  chk_pause_strap: assert property (disable iff (1'b0)
    i_sys_rst && strap_ok[1] |=> o_pause_en == $past(strap_s3_r[1]))
    else $error("pause strap not loaded");
  chk_speed_write: assert property (wr_high |=> o_speed_10 == $past(i_reg_wdata[4]))
    else $error("speed bit not written");
  chk_speed_strap: assert property (disable iff (1'b0)
    i_sys_rst && strap_ok[0] |=> o_speed_10 == $past(strap_s3_r[0]))
    else $error("speed strap not loaded");
  chk_null_vid: assert property (wr_high |=> o_null_vid_replace == $past(i_reg_wdata[3]))
    else $error("null vid bit not written");
  chk_rate_split: assert property (wr_high && !wr_low
    |=> o_storm_rate[10:8] == $past(i_reg_wdata[2:0]) && $stable(o_storm_rate[7:0]))
    else $error("storm rate high bits wrong");
  chk_period_len: assert property (tick_100 |=> !tick_100 [*8])
    else $error("storm period too short");
  chk_rate_reset: assert property (disable iff (1'b0) i_sys_rst |=> o_storm_rate == 11'h04a)
    else $error("storm rate reset wrong");
  chk_drop_clear: assert property (tick_100 && !i_port_speed_10[0] |=> !o_bcast_drop[0])
    else $error("drop not cleared at period");
  chk_ftest_fixed: assert property (i_reg_rd && hit(i_reg_addr, 8'h09)
    |=> o_reg_rdata == 8'h4c)
    else $error("factory test value wrong");

  cov_storm_drop: cover property (!o_bcast_drop[0] ##1 o_bcast_drop[0]);
  cov_slow_tick: cover property (tick_10);
  cov_half_duplex: cover property (wr_high && i_reg_wdata[6]);

endmodule : port5_link_and_storm_control_regs

`default_nettype wire

// ### verif/port5_link_and_storm_control_regs_test.sv
// self-checking bench for the port-5 link and storm control registers
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin errors++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); end end

module port5_link_and_storm_control_regs_test;
  // -----------------------------------------------------------------
  // signals and design
  // -----------------------------------------------------------------
  localparam int P100 = 20;
  typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r;} row_t;
  logic        i_mclk = 1'b0, i_sys_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic [7:0]  i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata, exp_hi, exp_lo;
  logic        i_duplex_strap_input = 1'b1, i_pause_strap_input = 1'b0;
  logic        i_speed_strap_input = 1'b1;
  logic        o_half_duplex, o_pause_en, o_speed_10, o_null_vid_replace;
  logic [10:0] o_storm_rate;
  logic [4:0]  i_port_speed_10 = 5'h02, i_bcast_block = 5'h00, o_bcast_drop;
  int          errors = 0, num_checks = 0, cyc = 0, n;
  row_t rows [8] = '{'{8'h06, 8'hff, 8'h7f}, '{8'h07, 8'ha5, 8'ha5}, '{8'h06, 8'h28, 8'h28},
                     '{8'h08, 8'hff, 8'h00}, '{8'h09, 8'h00, 8'h4c}, '{8'h0a, 8'hff, 8'h00},
                     '{8'h0b, 8'hff, 8'h48}, '{8'h20, 8'hff, 8'h00}};

  port5_link_and_storm_control_regs #(.NUM_PORTS(5), .P100_CYC(P100)) DUT (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .i_duplex_strap_input(i_duplex_strap_input), .i_pause_strap_input(i_pause_strap_input),
    .i_speed_strap_input(i_speed_strap_input), .o_half_duplex(o_half_duplex),
    .o_pause_en(o_pause_en), .o_speed_10(o_speed_10), .o_null_vid_replace(o_null_vid_replace),
    .o_storm_rate(o_storm_rate), .i_port_speed_10(i_port_speed_10),
    .i_bcast_block(i_bcast_block), .o_bcast_drop(o_bcast_drop));

  initial begin
    forever #5 i_mclk = ~i_mclk;
  end

  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      give_verdict();
    end
  end

  // -----------------------------------------------------------------
  // tasks
  // -----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_reg_wr    <= wr;
    i_reg_rd    <= ~wr;
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    @(posedge i_mclk);
    i_reg_wr <= 1'b0;
    i_reg_rd <= 1'b0;
    #1;
  endtask : access

  task automatic do_reset(input logic d, input logic p, input logic s);
    i_sys_rst            <= 1'b1;
    i_duplex_strap_input <= d;
    i_pause_strap_input  <= p;
    i_speed_strap_input  <= s;
    repeat (8) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    @(posedge i_mclk);
    #1;
    `CHK("rst half_duplex", d, o_half_duplex)
    `CHK("rst pause_en", p, o_pause_en)
    `CHK("rst speed_10", s, o_speed_10)
    `CHK("rst storm_rate", 11'h04a, o_storm_rate)
    `CHK("rst null_vid", 1'b0, o_null_vid_replace)
    `CHK("rst drop", 5'h00, o_bcast_drop)
    access(1'b0, 8'h07, 8'h00);
    `CHK("rst rd 07", 8'h4a, o_reg_rdata)
    access(1'b0, 8'h06, 8'h00);
    `CHK("rst rd 06", {1'b0, d, p, s, 4'h0}, o_reg_rdata)
  endtask : do_reset

  task automatic wait_fall(input int p, output int cnt);
    logic prev;
    cnt  = 0;
    prev = o_bcast_drop[p];
    do begin
      @(posedge i_mclk);
      #1;
      cnt++;
      if (prev === 1'b1 && o_bcast_drop[p] === 1'b0) break;
      prev = o_bcast_drop[p];
    end while (cnt < 400);
  endtask : wait_fall

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    do_reset(1'b1, 1'b0, 1'b1);
    exp_hi = 8'h50;
    exp_lo = 8'h4a;
    foreach (rows[i]) begin
      access(1'b1, rows[i].a, rows[i].w);
      if (rows[i].a == 8'h06) exp_hi = rows[i].w & 8'h7f;
      if (rows[i].a == 8'h07) exp_lo = rows[i].w;
      `CHK("half_duplex", exp_hi[6], o_half_duplex)
      `CHK("pause_en", exp_hi[5], o_pause_en)
      `CHK("speed_10", exp_hi[4], o_speed_10)
      `CHK("null_vid", exp_hi[3], o_null_vid_replace)
      `CHK("storm_rate", {exp_hi[2:0], exp_lo}, o_storm_rate)
      access(1'b0, rows[i].a, 8'h00);
      `CHK("readback", rows[i].r, o_reg_rdata)
    end
    // storm threshold of 2 blocks, ports 0 and 1 flooded
    access(1'b1, 8'h06, 8'h00);
    access(1'b1, 8'h07, 8'h02);
    @(posedge i_mclk);
    i_bcast_block <= 5'h03;
    wait_fall(0, n);
    wait_fall(0, n);
    `CHK("period 100M", P100, n)
    wait_fall(1, n);
    wait_fall(1, n);
    `CHK("period 10M", 10 * P100, n)
    // port-1 fall marks a shared boundary; stop flood and ride to the next one
    @(posedge i_mclk);
    i_bcast_block <= 5'h00;
    repeat (P100 - 1) @(posedge i_mclk);
    i_bcast_block <= 5'h05;
    repeat (2) @(posedge i_mclk);
    i_bcast_block <= 5'h04;
    @(posedge i_mclk);
    i_bcast_block <= 5'h00;
    repeat (2) @(posedge i_mclk);
    #1;
    `CHK("drop at threshold", 1'b0, o_bcast_drop[0])
    `CHK("drop above threshold", 1'b1, o_bcast_drop[2])
    wait_fall(2, n);
    `CHK("drop clears at boundary", P100 - 5, n)
    @(posedge i_mclk);
    do_reset(1'b0, 1'b1, 1'b0);
    give_verdict();
  end
endmodule : port5_link_and_storm_control_regs_test
`undef CHK
`default_nettype wire
